// [verilog/hpps_top.sv]
// Hub downstream port power, strap and shared pin control
// Operation
// - The gang mode pin is an input from reset until the strapped pins are released.
// - With gang strap 1 the gang pin drives 0 in normal operation and 1 in suspend.
// - With gang strap 0 the gang pin drives 1 in normal operation and 0 in suspend.
// - Test select 0 means normal operation and 1 puts the chip in test mode.
// - Each port has amber and green LED outputs, active high by default.
// - Each port power enable is active low by default and can be put in high impedance.
// - A strap on the port 2 amber pin selects the power enable polarity.
// - Each port has an active low overcurrent input driven by the outside circuit.
// - Green LED pin straps mark ports as non removable at reset.
// - Strapped pins become outputs 60 ms after reset, the outside must release them.
// - Port 1 and 2 LED pins can serve as SPI EEPROM select, clock, data out and data in.
// - Test pin can be I2C clock and port 1 power pin I2C data for an I2C EEPROM.
`timescale 1ns/1ps
module hpps_top #(
   parameter int NPORT = hpps_pkg::NUM_PORTS,
   parameter int HOLD_CYC = hpps_pkg::STRAP_HOLD_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Core controls
   input wire logic suspend,
   input wire logic [NPORT-1:0] port_power_on,
   input wire logic [NPORT-1:0] port_power_hiz,
   input wire logic [NPORT-1:0] led_amber_on,
   input wire logic [NPORT-1:0] led_green_on,
   input wire hpps_pkg::hpps_func_t func_sel,
   // EEPROM master signals to and from the core
   input wire logic spi_cs,
   input wire logic eeprom_serial_clock,
   input wire logic spi_mosi,
   output logic spi_miso,
   input wire logic i2c_scl_drive_low,
   input wire logic i2c_sda_drive_low,
   output logic i2c_sda_in,
   output logic i2c_scl_in,
   // Gang pin
   input wire logic gang_i,
   output logic gang_o,
   output logic gang_oe,
   // Test / I2C clock pin
   input wire logic test_i,
   output logic test_o,
   output logic test_oe,
   // Amber LED pins
   input wire logic [NPORT-1:0] amber_i,
   output logic [NPORT-1:0] amber_o,
   output logic [NPORT-1:0] amber_oe,
   // Green LED pins
   input wire logic [NPORT-1:0] green_i,
   output logic [NPORT-1:0] green_o,
   output logic [NPORT-1:0] green_oe,
   // Power enable pins
   input wire logic [NPORT-1:0] pwr_i,
   output logic [NPORT-1:0] port_power_enable_out,
   output logic [NPORT-1:0] port_power_enable_oe,
   // Overcurrent pins
   input wire logic [NPORT-1:0] port_overcurrent_in,
   // Status to the core
   output logic [NPORT-1:0] port_overcurrent,
   output hpps_pkg::hpps_straps_t straps,
   output logic test_mode,
   output logic pins_released
);
   localparam int CW = $clog2(HOLD_CYC + 1);
   localparam int SW = 3 + 2 * NPORT + 2;

   hpps_pkg::hpps_state_t state_ff, nxt_state;
   logic [CW-1:0] cnt_ff;
   hpps_pkg::hpps_straps_t straps_ff;
   logic test_ff;
   logic [SW-1:0] pin_raw, pin_s;
   logic [NPORT-1:0] ovr_s, amb_s, grn_s;
   logic gang_s, test_s, pwr1_s;

   assign pin_raw = {gang_i, test_i, pwr_i[0], amber_i, green_i, 1'b0, 1'b0};

   hpps_sync #(.WIDTH(SW)) u_pin_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(pin_raw),
      .sync_out(pin_s)
   );

   hpps_sync #(.WIDTH(NPORT)) u_ovr_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(port_overcurrent_in),
      .sync_out(ovr_s)
   );

   assign gang_s = pin_s[SW-1];
   assign test_s = pin_s[SW-2];
   assign pwr1_s = pin_s[SW-3];
   assign amb_s = pin_s[2*NPORT+1:NPORT+2];
   assign grn_s = pin_s[NPORT+1:2];

   // Sample waits for the synchroniser to fill so that pin levels are real
   logic [1:0] warm_ff;
   wire warm_done = (warm_ff == 2'h3);
   wire hold_done = (cnt_ff == CW'(HOLD_CYC - 1));
   wire run = (state_ff == hpps_pkg::HPPS_RUN);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         hpps_pkg::HPPS_SAMPLE: if (warm_done) nxt_state = hpps_pkg::HPPS_HOLD;
         hpps_pkg::HPPS_HOLD: if (hold_done) nxt_state = hpps_pkg::HPPS_RUN;
         hpps_pkg::HPPS_RUN: nxt_state = hpps_pkg::HPPS_RUN;
         default: nxt_state = hpps_pkg::HPPS_SAMPLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= hpps_pkg::HPPS_SAMPLE;
         warm_ff <= 2'h0;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (!warm_done) warm_ff <= warm_ff + 2'h1;
         if (state_ff == hpps_pkg::HPPS_HOLD) cnt_ff <= cnt_ff + CW'(1);
      end
   end

   // Latched once at the end of sampling; pins driven later cannot disturb them
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         straps_ff <= '0;
      end else if (state_ff == hpps_pkg::HPPS_SAMPLE && warm_done) begin
         straps_ff.gang_mode <= gang_s;
         straps_ff.enable_active_high <= amb_s[1];
         straps_ff.test_mode <= 1'b0;
         straps_ff.nonremovable <= grn_s;
      end
   end

   // Test select stays live while the pin is not used as I2C clock
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) test_ff <= hpps_pkg::STRAP_RST;
      else if (!func_sel.i2c_sel) test_ff <= test_s;
   end

   // Next pin values
   wire nxt_gang_o = straps_ff.gang_mode ? suspend : !suspend;
   wire nxt_gang_oe = run;
   wire [NPORT-1:0] pwr_lvl = straps_ff.enable_active_high ? port_power_on : ~port_power_on;
   logic [NPORT-1:0] nxt_pwr_o, nxt_pwr_oe, nxt_amb_o, nxt_grn_o;
   wire spi_on = func_sel.spi_sel && run;
   wire i2c_on = func_sel.i2c_sel && run;

   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_port
         if (g == 0) begin : g_p1
            assign nxt_pwr_o[g] = i2c_on ? 1'b0 : pwr_lvl[g];
            assign nxt_pwr_oe[g] = i2c_on ? i2c_sda_drive_low : run && !port_power_hiz[g];
            assign nxt_amb_o[g] = spi_on ? spi_cs : led_amber_on[g];
            assign nxt_grn_o[g] = spi_on ? eeprom_serial_clock : led_green_on[g];
         end else if (g == 1) begin : g_p2
            assign nxt_pwr_o[g] = pwr_lvl[g];
            assign nxt_pwr_oe[g] = run && !port_power_hiz[g];
            assign nxt_amb_o[g] = spi_on ? spi_mosi : led_amber_on[g];
            assign nxt_grn_o[g] = spi_on ? 1'b0 : led_green_on[g];
         end else begin : g_pn
            assign nxt_pwr_o[g] = pwr_lvl[g];
            assign nxt_pwr_oe[g] = run && !port_power_hiz[g];
            assign nxt_amb_o[g] = led_amber_on[g];
            assign nxt_grn_o[g] = led_green_on[g];
         end
      end
   endgenerate

   // Green pin 2 is the SPI data input while SPI is selected
   wire [NPORT-1:0] nxt_grn_oe = {NPORT{run}} & ~({{(NPORT-1){1'b0}}, spi_on} << 1);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gang_o <= 1'b0;
         gang_oe <= 1'b0;
         test_o <= 1'b0;
         test_oe <= 1'b0;
         amber_o <= '0;
         amber_oe <= '0;
         green_o <= '0;
         green_oe <= '0;
         port_power_enable_out <= '0;
         port_power_enable_oe <= '0;
         port_overcurrent <= '0;
         spi_miso <= 1'b0;
         i2c_sda_in <= 1'b1;
         i2c_scl_in <= 1'b1;
         straps <= '0;
         test_mode <= 1'b0;
         pins_released <= 1'b0;
      end else begin
         gang_o <= nxt_gang_o;
         gang_oe <= nxt_gang_oe;
         test_o <= 1'b0;
         test_oe <= i2c_on && i2c_scl_drive_low;
         amber_o <= nxt_amb_o;
         amber_oe <= {NPORT{run}};
         green_o <= nxt_grn_o;
         green_oe <= nxt_grn_oe;
         port_power_enable_out <= nxt_pwr_o;
         port_power_enable_oe <= nxt_pwr_oe;
         port_overcurrent <= ~ovr_s;
         spi_miso <= grn_s[1];
         i2c_sda_in <= pwr1_s;
         i2c_scl_in <= test_s;
         straps <= straps_ff;
         test_mode <= test_ff;
         pins_released <= run;
      end
   end

   sequence s_gang_read;
      (state_ff == hpps_pkg::HPPS_SAMPLE) && warm_done;
   endsequence

   property p_gang_input;
      @(posedge core_clk) disable iff (sys_rst) !run |=> !gang_oe;
   endproperty
   a_gang_input: assert property (p_gang_input) else $error("gang pin driven early");

   property p_gang_hi;
      @(posedge core_clk) disable iff (sys_rst)
         run && straps_ff.gang_mode |=> gang_o == $past(suspend);
   endproperty
   a_gang_hi: assert property (p_gang_hi) else $error("gang level wrong");

   property p_gang_lo;
      @(posedge core_clk) disable iff (sys_rst)
         run && !straps_ff.gang_mode |=> gang_o == !$past(suspend);
   endproperty
   a_gang_lo: assert property (p_gang_lo) else $error("individual level wrong");

   property p_test;
      @(posedge core_clk) disable iff (sys_rst)
         !func_sel.i2c_sel ##1 !$past(func_sel.i2c_sel) |=> test_mode == $past(test_s, 2);
   endproperty
   a_test: assert property (p_test) else $error("test mode mismatch");

   property p_pol;
      @(posedge core_clk) disable iff (sys_rst)
         run && !straps_ff.enable_active_high && !func_sel.i2c_sel
         |=> port_power_enable_out[NPORT-1] == !$past(port_power_on[NPORT-1]);
   endproperty
   a_pol: assert property (p_pol) else $error("enable polarity wrong");

   property p_ovr;
      @(posedge core_clk) disable iff (sys_rst)
         !ovr_s[0] |=> port_overcurrent[0];
   endproperty
   a_ovr: assert property (p_ovr) else $error("overcurrent lost");

   property p_strap;
      @(posedge core_clk) disable iff (sys_rst)
         s_gang_read |=> straps_ff.nonremovable == $past(grn_s);
   endproperty
   a_strap: assert property (p_strap) else $error("strap not latched");

   property p_hold;
      @(posedge core_clk) disable iff (sys_rst)
         s_gang_read |=> !run [*2];
   endproperty
   a_hold: assert property (p_hold) else $error("pins released too soon");

   property p_stable;
      @(posedge core_clk) disable iff (sys_rst) run |=> $stable(straps_ff);
   endproperty
   a_stable: assert property (p_stable) else $error("strap changed");
endmodule

// [verilog/hpps_pkg.sv]
// Package for the hub port power and strap pin block
package hpps_pkg;
   // Time from reset release until shared strap pins turn into outputs
   localparam int STRAP_HOLD_MS = 60;
   localparam int CLK_HZ = 10000000;
   localparam int STRAP_HOLD_CYC = (STRAP_HOLD_MS * CLK_HZ) / 1000;
   localparam int NUM_PORTS = 4;
   // Reset value of the live test select register
   localparam logic STRAP_RST = 1'h0;

   typedef enum logic [1:0] {
      HPPS_SAMPLE = 2'h0,
      HPPS_HOLD = 2'h1,
      HPPS_RUN = 2'h2
   } hpps_state_t;

   typedef struct packed {
      logic gang_mode;
      logic enable_active_high;
      logic test_mode;
      logic [NUM_PORTS-1:0] nonremovable;
   } hpps_straps_t;

   // Pin function select for the port 1/2 LED pins and shared I2C pins
   typedef struct packed {
      logic spi_sel;
      logic i2c_sel;
   } hpps_func_t;
endpackage

// [verilog/hpps_sync.sv]
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
module hpps_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

// [bench/hpps_partner.sv]
// Far side model: strap resistors, power switches, LEDs and EEPROM pins
`timescale 1ns/1ps
module hpps_partner (
   // Reset
   input wire logic sys_rst,
   // Strap levels and far side stimulus
   input wire logic gang_strap,
   input wire logic pol_strap,
   input wire logic [3:0] fixed_strap,
   input wire logic test_sel,
   input wire logic miso,
   input wire logic [3:0] oc_req,
   // Device pin drivers
   input wire logic gang_o,
   input wire logic gang_oe,
   input wire logic test_o,
   input wire logic test_oe,
   input wire logic [3:0] amber_o,
   input wire logic [3:0] amber_oe,
   input wire logic [3:0] green_o,
   input wire logic [3:0] green_oe,
   input wire logic [3:0] pwr_o,
   input wire logic [3:0] pwr_oe,
   // Wire levels seen by the device
   output logic gang_i,
   output logic test_i,
   output logic [3:0] amber_i,
   output logic [3:0] green_i,
   output logic [3:0] pwr_i,
   output logic [3:0] oc_n
);
   logic rel;
   // High straps let go once the device first drives its pins, else they fight the LEDs
   // Level sensitive so that the first reset clears it without needing an edge
   always_latch begin
      if (sys_rst) rel <= 1'h0;
      else if (gang_oe) rel <= 1'h1;
   end
   assign gang_i = gang_oe ? gang_o : (!rel & gang_strap);
   assign test_i = test_oe ? test_o : test_sel;
   assign amber_i = (amber_oe & amber_o) | (~amber_oe & {2'h0, !rel & pol_strap, 1'h0});
   assign green_i = (green_oe & green_o) |
      (~green_oe & (rel ? {2'h0, miso, 1'h0} : fixed_strap));
   // Pull-up on the power pins doubles as the SDA pull-up
   assign pwr_i = (pwr_oe & pwr_o) | ~pwr_oe;
   assign oc_n = ~oc_req;
endmodule

// [bench/hpps_top_bench.sv]
// Self-checking bench for the hub port power and strap pin block
`timescale 1ns/1ps
module hpps_top_bench;
   localparam int HOLD = 20;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic suspend, cs, sck, mosi, sdl, scl_dl, gang_s, pol_s, tsel, miso;
   logic [3:0] pw_on, pw_hiz, am_on, gr_on, oc_req, fx;
   hpps_pkg::hpps_func_t fsel;
   logic spi_miso, sda_in, scl_in, gang_o, gang_oe, test_o, test_oe, test_mode, rel;
   logic gang_i, test_i;
   logic [3:0] amber_o, amber_oe, green_o, green_oe, pwr_o, pwr_oe, oc;
   logic [3:0] amber_i, green_i, pwr_i, oc_n;
   hpps_pkg::hpps_straps_t straps;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int mid;
   logic [7:0] mexp;
   int id_q[$];
   logic [7:0] exp_q[$];
   event take;
   logic busy = 1'h0;

   hpps_top #(.NPORT(4), .HOLD_CYC(HOLD)) hpps_top_i (
      .core_clk(core_clk), .sys_rst(sys_rst), .suspend(suspend), .port_power_on(pw_on),
      .port_power_hiz(pw_hiz), .led_amber_on(am_on), .led_green_on(gr_on), .func_sel(fsel),
      .spi_cs(cs), .eeprom_serial_clock(sck), .spi_mosi(mosi), .spi_miso(spi_miso),
      .i2c_scl_drive_low(scl_dl), .i2c_sda_drive_low(sdl), .i2c_sda_in(sda_in),
      .i2c_scl_in(scl_in), .gang_i(gang_i), .gang_o(gang_o), .gang_oe(gang_oe),
      .test_i(test_i), .test_o(test_o), .test_oe(test_oe), .amber_i(amber_i),
      .amber_o(amber_o), .amber_oe(amber_oe), .green_i(green_i), .green_o(green_o),
      .green_oe(green_oe), .pwr_i(pwr_i), .port_power_enable_out(pwr_o),
      .port_power_enable_oe(pwr_oe), .port_overcurrent_in(oc_n), .port_overcurrent(oc),
      .straps(straps), .test_mode(test_mode), .pins_released(rel));

   hpps_partner hpps_partner_i (
      .sys_rst(sys_rst), .gang_strap(gang_s), .pol_strap(pol_s), .fixed_strap(fx),
      .test_sel(tsel), .miso(miso), .oc_req(oc_req), .gang_o(gang_o), .gang_oe(gang_oe),
      .test_o(test_o), .test_oe(test_oe), .amber_o(amber_o), .amber_oe(amber_oe),
      .green_o(green_o), .green_oe(green_oe), .pwr_o(pwr_o), .pwr_oe(pwr_oe),
      .gang_i(gang_i), .test_i(test_i), .amber_i(amber_i), .green_i(green_i),
      .pwr_i(pwr_i), .oc_n(oc_n));

   always #50 core_clk = ~core_clk;

   // Observed value for each kind of note
   function automatic logic [7:0] seen(int id);
      case (id)
         0: seen = {3'h0, gang_oe, |amber_oe, |green_oe, |pwr_oe, rel};
         1: seen = {1'h0, straps};
         2: seen = {7'h0, gang_o};
         3: seen = {pwr_o & pwr_oe, pwr_oe};
         4: seen = {amber_o, green_o};
         5: seen = {4'h0, oc};
         6: seen = {7'h0, test_mode};
         7: seen = {3'h0, amber_o[1:0], green_o[0], spi_miso, green_oe[1]};
         default: seen = {2'h0, pwr_oe[0], pwr_o[0], test_oe, test_o, sda_in, scl_in};
      endcase
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic note(int id, logic [7:0] v);
      id_q.push_back(id);
      exp_q.push_back(v);
   endtask

   // The slowest pin paths take four edges; stimulus waits until the notes are drained
   task automatic check(int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
      busy = 1'h1;
      ->take;
      wait (!busy);
   endtask

   always @(take) begin
      while (id_q.size() > 0) begin
         mid = id_q.pop_front();
         mexp = exp_q.pop_front();
         tests_run++;
         if (seen(mid) !== mexp) begin
            fail_count++;
            $display("BAD t=%0t note %0d got %h want %h", $time, mid, seen(mid), mexp);
         end
      end
      busy = 1'h0;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         print_verdict();
      end
   end

   initial begin
      {suspend, pw_on, pw_hiz, am_on, gr_on, oc_req, fx, fsel} = '0;
      {cs, sck, mosi, sdl, scl_dl, gang_s, pol_s, tsel, miso} = '0;
      void'($urandom(32'h2BF26D58));
      // Each round is a fresh reset, so relatching is seen mid-run
      for (int r = 0; r < 4; r++) begin
         @(negedge core_clk);
         sys_rst = 1'h1;
         {gang_s, pol_s} = 2'(r);
         fx = 4'($urandom);
         tsel = 1'h0;
         repeat (16) @(negedge core_clk);
         sys_rst = 1'h0;
         repeat (8) @(negedge core_clk);
         note(0, 8'h00);
         note(1, {1'h0, gang_s, pol_s, 1'h0, fx});
         check(0);
         for (int i = 0; i < 40 && rel !== 1'h1; i++) @(negedge core_clk);
         {suspend, pw_on, pw_hiz, am_on, gr_on, oc_req, tsel} = 22'($urandom);
         note(0, {3'h0, 3'h7, |(~pw_hiz), 1'h1});
         note(1, {1'h0, gang_s, pol_s, 1'h0, fx});
         note(2, {7'h0, gang_s ? suspend : !suspend});
         note(3, {(pol_s ? pw_on : ~pw_on) & ~pw_hiz, ~pw_hiz});
         note(4, {am_on, gr_on});
         note(5, {4'h0, oc_req});
         note(6, {7'h0, tsel});
         check(4);
         fsel = 2'h2;
         {cs, sck, mosi, miso} = 4'($urandom);
         note(7, {3'h0, mosi, cs, sck, miso, 1'h0});
         check(4);
         fsel = 2'h1;
         tsel = 1'h1;
         {sdl, scl_dl} = 2'($urandom);
         note(8, {2'h0, sdl, 1'h0, scl_dl, 1'h0, !sdl, !scl_dl});
         check(4);
         fsel = 2'h0;
         {sdl, scl_dl} = 2'h0;
      end
      print_verdict();
   end
endmodule
